// *** hdl/mgp_defines.vh ***
// Purpose: Offsets, field positions, reset values and timing counts of the metering configuration bank.
// Assumes: Wishbone byte addresses are four times the printed register index.
// Notes: Included by mgp_config.v and by the testbench.
`ifndef MGP_DEFINES_VH
`define MGP_DEFINES_VH

// ****************************************
// Register indices and byte addresses
// ****************************************
`define MGP_IDX_PATH_CTRL3   16'h287a
`define MGP_IDX_PHASE_CTRL1  16'h287b
`define MGP_IDX_NOLOAD_STAT  16'h287f
`define MGP_IDX_IRQ_STATUS   16'h2880
`define MGP_IDX_IRQ_MASK     16'h2881
`define MGP_IDX_MISC_CTRL    16'h2882
`define MGP_ADDR_PATH_CTRL3  18'h0a1e8
`define MGP_ADDR_PHASE_CTRL1 18'h0a1ec
`define MGP_ADDR_NOLOAD_STAT 18'h0a1fc
`define MGP_ADDR_IRQ_STATUS  18'h0a200
`define MGP_ADDR_IRQ_MASK    18'h0a204
`define MGP_ADDR_MISC_CTRL   18'h0a208

// ****************************************
// Field positions
// ****************************************
`define MGP_BIT_ZC_IRQ_EN    7
`define MGP_BIT_RMS_BPF_EN   6
`define MGP_BIT_V_QUARTER    5
`define MGP_BIT_PATH2_SEL    4
`define MGP_BIT_CH2_SIGN     3
`define MGP_BIT_DLY_TARGET   7
`define MGP_BIT_PHC_EN       6
`define MGP_BIT_IRQ_ZC       0
`define MGP_BIT_IRQ_GAINERR  1

// ****************************************
// Reset values
// ****************************************
`define MGP_RST_PATH_CTRL3   8'h00
`define MGP_RST_PHASE_CTRL1  8'h00
`define MGP_RST_NOLOAD_STAT  8'h00
`define MGP_RST_MISC_CTRL    8'h00
`define MGP_RST_IRQ          8'h00
`define MGP_GAIN_EXP_MAX     3'h5

// ****************************************
// Timing
// ****************************************
`define MGP_CLK_HZ           40000000
`define MGP_SMPL_HZ          3276800
// Rounded down; the sampler runs slightly fast of the nominal rate.
`define MGP_SMPL_DIV         (`MGP_CLK_HZ / `MGP_SMPL_HZ)
// Last divider count, one below the rounded-down ratio of twelve.
`define MGP_SMPL_LAST        4'hb
`define MGP_DLY_MAX          256

`endif

// *** hdl/mgp_config.v ***
// Purpose: Register bank and signal shaping for the metering gain and phase configuration.
// Assumes: One 40 MHz clock, synchronous active-high reset, classic Wishbone slave.
// Notes: Samples are signed 24-bit words, one per phase-compensation sample enable.
//   Register map, byte address and purpose:
//   0xa1e8 path control three: irq enable, filter, quarter gain, path select, channel-two gain.
//   0xa1ec phase delay control one: delay target and upper six delay bits.
//   0xa1fc no-load status, read only: the lower two delay bits.
//   0xa200 interrupt status, write one to clear.
//   0xa204 interrupt mask, same layout as the status.
//   0xa208 misc control: compensation enable and voltage gain exponent.
//   Only byte lane zero carries data; the upper lanes read as zero.
//
// What this block does
// - Zero-cross interrupt forwarded only when enabled
// - Band-pass in RMS path when enabled
// - Quarter bit divides voltage gain by four
// - Select one: path two meters channel two
// - Select zero: path two meters channel-one reactive
// - Positive current gives negative reactive energy
// - Sign bit negates channel-two gain
// - Channel-two gain is two to exponent
// - Target bit picks voltage or current delay
// - Delay is upper six plus lower two
// - Steps once per sample strobe, every twelve clocks
// - Delays only act when compensation enabled
// - Voltage gain two to exponent, before quarter
`timescale 1ns/1ps
`include "mgp_defines.vh"

module mgp_config (
  // Clock and reset
  input  wire               clk_i,
  input  wire               rst_i,
  // Wishbone slave
  input  wire               cyc_i,
  input  wire               stb_i,
  input  wire               we_i,
  input  wire [17:0]        adr_i,
  input  wire [3:0]         sel_i,
  input  wire [31:0]        dat_i,
  output reg  [31:0]        dat_o,
  output reg                ack_o,
  // Metering events and status
  input  wire               zero_cross_i,
  input  wire [1:0]         noload_status_i,
  output wire               irq_o,
  // Sample inputs
  input  wire signed [23:0] voltage_i,
  input  wire signed [23:0] current1_i,
  input  wire signed [23:0] current2_i,
  // Shaped samples and path selects
  output reg  signed [23:0] voltage_o,
  output reg  signed [23:0] current1_o,
  output reg  signed [23:0] current2_o,
  output reg                smpl_en_o,
  output wire               rms_bandpass_enable_o,
  output wire               path2_active_ch2_o,
  output wire               path2_reactive_ch1_o,
  output wire               reactive_to_negative_o
);

  // ****************************************
  // Registers
  // ****************************************
  // The misc register holds settings whose home register lies outside this bank.
  // The no-load copy is refreshed every clock and is never written by software.
  reg  [7:0] path_ctrl3_r;
  reg  [7:0] phase_ctrl1_r;
  reg  [7:0] misc_ctrl_r;
  reg  [7:0] noload_stat_r;
  reg  [7:0] irq_status_r;
  reg  [7:0] irq_mask_r;
  wire [7:0] irq_status_nxt;
  wire       irq_clr_stb;
  reg  [7:0] rd_data;
  reg        zc_d_r;
  reg  [3:0] div_cnt_r;
  wire       wr_stb;
  wire       rd_stb;
  wire [7:0] irq_event;
  wire       zero_cross_irq_enable;
  wire       voltage_gain_quarter;
  wire       second_path_function_select;
  wire       channel_two_gain_sign;
  wire [2:0] channel_two_gain_exponent;
  wire [2:0] voltage_gain_exponent;
  wire       ch1_delay_target_select;
  wire       phase_compensation_enable;
  wire [7:0] ch1_phase_delay;

  assign zero_cross_irq_enable       = path_ctrl3_r[`MGP_BIT_ZC_IRQ_EN];
  assign rms_bandpass_enable_o       = path_ctrl3_r[`MGP_BIT_RMS_BPF_EN];
  assign voltage_gain_quarter        = path_ctrl3_r[`MGP_BIT_V_QUARTER];
  assign second_path_function_select = path_ctrl3_r[`MGP_BIT_PATH2_SEL];
  assign channel_two_gain_sign       = path_ctrl3_r[`MGP_BIT_CH2_SIGN];
  assign channel_two_gain_exponent   = path_ctrl3_r[2:0];
  assign voltage_gain_exponent       = misc_ctrl_r[2:0];
  assign phase_compensation_enable   = misc_ctrl_r[`MGP_BIT_PHC_EN];
  assign ch1_delay_target_select     = phase_ctrl1_r[`MGP_BIT_DLY_TARGET];
  assign ch1_phase_delay             = {phase_ctrl1_r[5:0], noload_stat_r[1:0]};

  assign path2_active_ch2_o     = second_path_function_select;
  assign path2_reactive_ch1_o   = ~second_path_function_select;
  // A positive channel-one current lands in the negative reactive accumulators.
  assign reactive_to_negative_o = ~second_path_function_select & ~current1_o[23];

  // ****************************************
  // Wishbone slave
  // ****************************************
  // Ack is registered, so every access answers one cycle after the strobe.
  // Reads have no side effects, so a master may repeat one freely.
  // Writes without byte lane zero are acknowledged but change nothing.
  assign wr_stb = cyc_i & stb_i & we_i & ~ack_o & sel_i[0];
  assign rd_stb = cyc_i & stb_i & ~ack_o;

  always @* begin
    if (adr_i == `MGP_ADDR_PATH_CTRL3) begin
      rd_data = path_ctrl3_r;
    end else if (adr_i == `MGP_ADDR_PHASE_CTRL1) begin
      rd_data = {phase_ctrl1_r[7], 1'b0, phase_ctrl1_r[5:0]};
    end else if (adr_i == `MGP_ADDR_NOLOAD_STAT) begin
      rd_data = noload_stat_r;
    end else if (adr_i == `MGP_ADDR_IRQ_STATUS) begin
      rd_data = irq_status_r;
    end else if (adr_i == `MGP_ADDR_IRQ_MASK) begin
      rd_data = irq_mask_r;
    end else if (adr_i == `MGP_ADDR_MISC_CTRL) begin
      rd_data = misc_ctrl_r;
    end else begin
      rd_data = 8'h00;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o         <= 1'b0;
      dat_o         <= 32'h0000_0000;
      path_ctrl3_r  <= `MGP_RST_PATH_CTRL3;
      phase_ctrl1_r <= `MGP_RST_PHASE_CTRL1;
      misc_ctrl_r   <= `MGP_RST_MISC_CTRL;
      irq_mask_r    <= `MGP_RST_IRQ;
      noload_stat_r <= `MGP_RST_NOLOAD_STAT;
    end else begin
      ack_o         <= cyc_i & stb_i & ~ack_o;
      noload_stat_r <= {6'h00, noload_status_i};
      if (rd_stb) begin
        dat_o <= {24'h00_0000, rd_data};
      end
      if (wr_stb) begin
        if (adr_i == `MGP_ADDR_PATH_CTRL3) begin
          path_ctrl3_r <= dat_i[7:0];
        end else if (adr_i == `MGP_ADDR_PHASE_CTRL1) begin
          phase_ctrl1_r <= {dat_i[7], 1'b0, dat_i[5:0]};
        end else if (adr_i == `MGP_ADDR_IRQ_MASK) begin
          irq_mask_r <= dat_i[7:0];
        end else if (adr_i == `MGP_ADDR_MISC_CTRL) begin
          misc_ctrl_r <= {1'b0, dat_i[6], 3'h0, dat_i[2:0]};
        end
      end
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  // Zero-cross events only register while forwarding is enabled.
  assign irq_event = {6'h00,
                      (channel_two_gain_exponent > `MGP_GAIN_EXP_MAX),
                      zero_cross_irq_enable & zero_cross_i & ~zc_d_r};

  assign irq_clr_stb = wr_stb & (adr_i == `MGP_ADDR_IRQ_STATUS);

  // A set in the same cycle as a write-one clear wins, so no event is lost.
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_irq_bit
      assign irq_status_nxt[gi] = irq_event[gi] | (irq_status_r[gi] & ~(irq_clr_stb & dat_i[gi]));
    end
  endgenerate

  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_status_r <= `MGP_RST_IRQ;
      zc_d_r       <= 1'b0;
    end else begin
      irq_status_r <= irq_status_nxt;
      zc_d_r       <= zero_cross_i;
    end
  end

  assign irq_o = |(irq_status_r & irq_mask_r);

  // ****************************************
  // Sample enable divider
  // ****************************************
  // The divide is rounded down, so strobes come slightly faster than nominal.
  // All sampled state moves only on this strobe, never on the raw clock.
  always @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt_r <= 4'h0;
      smpl_en_o <= 1'b0;
    end else if (div_cnt_r == `MGP_SMPL_LAST) begin
      div_cnt_r <= 4'h0;
      smpl_en_o <= 1'b1;
    end else begin
      div_cnt_r <= div_cnt_r + 4'h1;
      smpl_en_o <= 1'b0;
    end
  end

  // ****************************************
  // Phase delay line and gain
  // ****************************************
  // The delay line costs 256 words; one line serves whichever signal is picked.
  // The memory has no reset; the bypass at zero delay hides its first contents.
  reg  signed [23:0] dly_mem [0:`MGP_DLY_MAX-1];
  reg  [7:0]         wr_ptr_r;
  reg  signed [23:0] dly_in;
  reg  signed [23:0] dly_out;
  reg  signed [23:0] v_src;
  reg  signed [23:0] i1_src;
  reg  signed [31:0] v_scaled;
  reg  signed [31:0] i2_scaled;
  wire [7:0]         rd_ptr;
  wire signed [31:0] v_wide;
  wire signed [31:0] i2_wide;

  assign rd_ptr = wr_ptr_r - ch1_phase_delay;

  // Sign extension keeps negative samples negative once shifted left.
  assign v_wide  = {{8{v_src[23]}}, v_src};
  assign i2_wide = {{8{current2_i[23]}}, current2_i};

  // ****************************************
  // Delay target selection
  // ****************************************
  // Only one signal is ever delayed, so one line of memory is shared.
  always @* begin
    dly_in  = ch1_delay_target_select ? voltage_i : current1_i;
    // A zero setting bypasses the memory, which avoids reading a stale word.
    dly_out = (ch1_phase_delay == 8'h00) ? dly_in : dly_mem[rd_ptr];
    v_src   = voltage_i;
    i1_src  = current1_i;
    if (phase_compensation_enable) begin
      if (ch1_delay_target_select) begin
        v_src = dly_out;
      end else begin
        i1_src = dly_out;
      end
    end
  end

  // ****************************************
  // Voltage gain
  // ****************************************
  // The quarter step follows the exponent shift, so inputs lose low bits only when the exponent is below two: two bits at zero, one bit at one.
  always @* begin
    v_scaled = v_wide <<< voltage_gain_exponent;
    if (voltage_gain_quarter) begin
      v_scaled = v_scaled >>> 2;
    end
  end

  // ****************************************
  // Channel-two gain
  // ****************************************
  // Exponents above five are not guarded here; they raise the gain error flag instead.
  always @* begin
    i2_scaled = i2_wide <<< channel_two_gain_exponent;
    if (channel_two_gain_sign) begin
      i2_scaled = -i2_scaled;
    end
  end

  always @(posedge clk_i) begin
    if (smpl_en_o) begin
      dly_mem[wr_ptr_r] <= dly_in;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_r   <= 8'h00;
      voltage_o  <= 24'sh00_0000;
      current1_o <= 24'sh00_0000;
      current2_o <= 24'sh00_0000;
    end else if (smpl_en_o) begin
      wr_ptr_r   <= wr_ptr_r + 8'h01;
      voltage_o  <= v_scaled[23:0];
      current1_o <= i1_src;
      current2_o <= i2_scaled[23:0];
    end
  end

endmodule // mgp_config

// *** verification/mgp_config_chk.sv ***
// Purpose: Port assertions for the metering configuration bank.
// Assumes: Single clock, synchronous active-high reset.
// Notes: Bound to every mgp_config instance.
`timescale 1ns/1ps
module mgp_config_chk (
  // Clock and reset
  input wire               clk_i,
  input wire               rst_i,
  // Bus
  input wire               cyc_i,
  input wire               stb_i,
  input wire               we_i,
  input wire [31:0]        dat_i,
  input wire               ack_o,
  // Datapath
  input wire               smpl_en_o,
  input wire signed [23:0] voltage_o,
  input wire signed [23:0] current1_o,
  input wire signed [23:0] current2_o,
  input wire               rms_bandpass_enable_o,
  input wire               path2_active_ch2_o,
  input wire               path2_reactive_ch1_o,
  input wire               reactive_to_negative_o
);
  // ****************
  // Assertions
  // ****************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Eleven quiet cycles separate two strobes.
  sequence s_quiet;
    !smpl_en_o [*8] ##1 !smpl_en_o [*3];
  endsequence
  a_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
  a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack too long");
  a_bpf_by_write: assert property (!$past(rst_i) && $changed(rms_bandpass_enable_o)
    |-> ack_o && we_i && dat_i[6] == rms_bandpass_enable_o) else $error("filter enable moved");
  a_path_by_write: assert property (!$past(rst_i) && $changed(path2_active_ch2_o)
    |-> ack_o && we_i && dat_i[4] == path2_active_ch2_o) else $error("path select moved");
  a_path_exclusive: assert property (path2_active_ch2_o != path2_reactive_ch1_o)
    else $error("path modes clash");
  a_reactive_sign: assert property (reactive_to_negative_o ==
    (path2_reactive_ch1_o && !current1_o[23])) else $error("reactive sign wrong");
  a_sample_period: assert property (smpl_en_o |=> s_quiet ##1 smpl_en_o)
    else $error("sample period wrong");
  a_out_hold: assert property (!$past(rst_i) && !$past(smpl_en_o)
    |-> $stable({voltage_o, current1_o, current2_o})) else $error("samples moved");
endmodule // mgp_config_chk

bind mgp_config mgp_config_chk chk_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .dat_i, .ack_o, .smpl_en_o,
  .voltage_o, .current1_o, .current2_o, .rms_bandpass_enable_o, .path2_active_ch2_o, .path2_reactive_ch1_o,
  .reactive_to_negative_o);

// *** verification/mgp_config_tb.sv ***
// Purpose: Self-checking bench for the metering configuration bank.
// Assumes: Wishbone classic master driven on rising edges.
// Notes: Phase delay is measured as a difference so pipeline depth cancels out.
`timescale 1ns/1ps
`include "mgp_defines.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module mgp_config_tb;
  reg               clk_i = 0;
  reg               rst_i = 1;
  reg               cyc_i = 0;
  reg               stb_i = 0;
  reg               we_i = 0;
  reg [17:0]        adr_i = 0;
  reg [3:0]         sel_i = 0;
  reg [31:0]        dat_i = 0;
  reg               zero_cross_i = 0;
  reg [1:0]         noload_status_i = 0;
  reg signed [23:0] voltage_i = 0;
  reg signed [23:0] current1_i = 0;
  reg signed [23:0] current2_i = 0;
  wire [31:0]       dat_o;
  wire signed [23:0] voltage_o, current1_o, current2_o;
  wire              ack_o, irq_o, smpl_en_o, rms_bandpass_enable_o;
  wire              path2_active_ch2_o, path2_reactive_ch1_o, reactive_to_negative_o;
  int               num_errors = 0;
  int               n_compared = 0;
  always #12.5 clk_i = ~clk_i;
  mgp_config dut_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
    .zero_cross_i, .noload_status_i, .irq_o, .voltage_i, .current1_i, .current2_i, .voltage_o,
    .current1_o, .current2_o, .smpl_en_o, .rms_bandpass_enable_o, .path2_active_ch2_o,
    .path2_reactive_ch1_o, .reactive_to_negative_o);
  task wb(input [17:0] a, input [7:0] d, input w, output [7:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, sel_i} <= {2'b11, w, 4'hf};
    {adr_i, dat_i} <= {a, 24'h0, d};
    do @(posedge clk_i); while (ack_o !== 1'b1 && ++n < 50);
    if (n == 50) begin
      num_errors++;
      final_report;
    end
    q = dat_o[7:0];
    {cyc_i, stb_i} <= 2'b00;
  endtask
  task wr(input [17:0] a, input [7:0] d);
    reg [7:0] q;
    wb(a, d, 1'b1, q);
  endtask
  task rdc(input [17:0] a, input [7:0] e);
    reg [7:0] q;
    wb(a, 8'h00, 1'b0, q);
    `CHK(q, e);
  endtask
  // Waits for n strobes, then lets the registered outputs settle.
  task smp(input int n);
    repeat (n) begin
      @(negedge clk_i);
      while (smpl_en_o !== 1'b1) @(negedge clk_i);
    end
    repeat (2) @(negedge clk_i);
  endtask
  task t_regs;
    rdc(`MGP_ADDR_PATH_CTRL3, 8'h00);
    rdc(`MGP_ADDR_PHASE_CTRL1, 8'h00);
    rdc(18'h0a1f0, 8'h00);
    wr(`MGP_ADDR_PATH_CTRL3, 8'hdd);
    rdc(`MGP_ADDR_PATH_CTRL3, 8'hdd);
    `CHK({rms_bandpass_enable_o, path2_active_ch2_o, path2_reactive_ch1_o}, 3'b110);
    wr(`MGP_ADDR_PHASE_CTRL1, 8'hff);
    rdc(`MGP_ADDR_PHASE_CTRL1, 8'hbf);
    wr(`MGP_ADDR_PATH_CTRL3, 8'h00);
    `CHK({rms_bandpass_enable_o, path2_active_ch2_o, path2_reactive_ch1_o}, 3'b001);
    $display("t_regs done");
  endtask
  task t_gain;
    current2_i <= 24'h10;
    voltage_i <= 24'h40;
    for (int s = 0; s < 2; s++) for (int e = 0; e < 6; e++) begin
      wr(`MGP_ADDR_PATH_CTRL3, {4'h0, s[0], e[2:0]});
      smp(2);
      `CHK(current2_o, s ? 24'h0 - (24'h10 << e) : 24'h10 << e);
    end
    wr(`MGP_ADDR_MISC_CTRL, 8'h03);
    rdc(`MGP_ADDR_MISC_CTRL, 8'h03);
    for (int q = 0; q < 2; q++) begin
      wr(`MGP_ADDR_PATH_CTRL3, {2'b00, q[0], 5'h00});
      smp(2);
      `CHK(voltage_o, q ? 24'h80 : 24'h200);
    end
    $display("t_gain done");
  endtask
  task zcp;
    zero_cross_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    zero_cross_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  task t_irq;
    wr(`MGP_ADDR_IRQ_MASK, 8'h01);
    wr(`MGP_ADDR_PATH_CTRL3, 8'h00);
    zcp;
    `CHK(irq_o, 1'b0);
    rdc(`MGP_ADDR_IRQ_STATUS, 8'h00);
    wr(`MGP_ADDR_PATH_CTRL3, 8'h80);
    zcp;
    `CHK(irq_o, 1'b1);
    rdc(`MGP_ADDR_IRQ_STATUS, 8'h01);
    wr(`MGP_ADDR_IRQ_MASK, 8'h00);
    `CHK(irq_o, 1'b0);
    wr(`MGP_ADDR_IRQ_MASK, 8'h01);
    `CHK(irq_o, 1'b1);
    wr(`MGP_ADDR_IRQ_STATUS, 8'h01);
    `CHK(irq_o, 1'b0);
    $display("t_irq done");
  endtask
  task meas(input [23:0] v, output int c);
    smp(8);
    @(posedge clk_i);
    current1_i <= v;
    c = 0;
    while (current1_o !== v && c < 40) begin
      smp(1);
      c++;
    end
  endtask
  task t_phase;
    int c0, c1;
    noload_status_i <= 2'h1;
    wr(`MGP_ADDR_PHASE_CTRL1, 8'h01);
    rdc(`MGP_ADDR_NOLOAD_STAT, 8'h01);
    wr(`MGP_ADDR_MISC_CTRL, 8'h00);
    meas(24'h000100, c0);
    `CHK(reactive_to_negative_o, 1'b1);
    wr(`MGP_ADDR_MISC_CTRL, 8'h40);
    meas(24'hffff00, c1);
    `CHK(reactive_to_negative_o, 1'b0);
    `CHK(c1 - c0, 5);
    $display("t_phase done");
  endtask
  task final_report;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_gain;
    t_irq;
    t_phase;
    final_report;
  end
  initial begin
    #500000;
    num_errors++;
    final_report;
  end
endmodule // mgp_config_tb
